/* File: dv/pfm_ext_mem.sv */
// Board-side external memory answering the multiplexed bus
`timescale 1ns/1ps
module pfm_ext_mem (
   // Clock
   input wire logic hclk,
   // Device pins
   input wire pfm_pkg::pfm_pin8_t ad_pin_q,
   input wire pfm_pkg::pfm_pin8_t hi_pin_q,
   input wire pfm_pkg::pfm_pin8_t led_pin_q,
   // Wait states asked per access
   input wire logic [3:0] wait_cyc,
   // Board levels back to the device, and the latched high address byte
   output logic [7:0] ad_drive,
   output logic wait_n,
   output logic [7:0] hi_lat
);
   import pfm_pkg::*;
   logic [7:0] mem [256];
   logic [7:0] lo_lat;
   logic [7:0] junk_q = 8'h5a;
   logic [3:0] wcnt = 4'h0;
   logic address_latch_strobe;
   logic rd_on;
   logic wr_on;
   // ==========================================================
   // Strobes as seen on the wire
   assign address_latch_strobe = led_pin_q.oe[7] & led_pin_q.o[7];
   assign rd_on = led_pin_q.oe[4] & ~led_pin_q.o[4];
   assign wr_on = led_pin_q.oe[5] & ~led_pin_q.o[5];
   assign wait_n = (wcnt == 4'h0);
   // Released bus shows a changing pattern, never the last data
   assign ad_drive = rd_on ? mem[lo_lat] : junk_q;
   always @(posedge hclk) begin
      junk_q <= ~junk_q + 8'h1;
      if (address_latch_strobe) begin
         lo_lat <= ad_pin_q.o;
         hi_lat <= hi_pin_q.o;
         wcnt <= wait_cyc;
      end else if ((rd_on | wr_on) && wcnt != 4'h0) begin
         wcnt <= wcnt - 4'h1;
      end
      if (wr_on) begin
         mem[lo_lat] <= ad_pin_q.o;
      end
   end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the port and pin-function map
`timescale 1ns/1ps
module testbench;
   import pfm_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_on = 0;
   logic hreadyout, hresp, ext_done_q, serial_auto_strobe_q;
   logic timer16_out_q, serial_busy_q, wait_n;
   logic tmr16_pwm = 0, serial_stb_int = 0, serial_busy_pin = 0, fbc = 0;
   logic [1:0] htrans = 0, tmr8_pin_in = 0;
   logic [2:0] timer_count_q;
   logic [3:0] ext_irq_pulse_q, expansion_ram_size_select_q;
   logic [3:0] wait_cyc = 0;
   logic [4:0] small_pin_in = 5'h10;
   logic [5:0] prom_pin_in = 0;
   logic [7:0] bench_ad = 8'hff, ext_rdata_q, memory_size_select_q;
   logic [7:0] ad_drive, hi_lat;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   pfm_pin8_t small_pin_q, ana_pin_q, ad_pin_q, hi_pin_q, led_pin_q;
   pfm_ext_req_t ext_req = '0;
   pfm_prom_mode_t prom_mode_q;
   int seed = 76, n_fail = 0, checked = 0;
   localparam logic [5:0] PCODE [9] = '{6'h00, 6'h31, 6'h32, 6'h34,
      6'h3d, 6'h3e, 6'h3a, 6'h39, 6'h3b};
   always #25 hclk = ~hclk;
   function automatic logic [7:0] wire8(pfm_pin8_t p, logic [7:0] e);
      return (p.oe & p.o) | (~p.oe & (p.pu | e));
   endfunction
   function automatic logic [31:0] eflag(int c, int m, int f);
      return 32'((c < 3 ? (m >> f) & 1 : f) << c);
   endfunction
   pfm_port_map uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .small_pin_in(small_pin_in), .small_pin_q(small_pin_q),
      .ana_pin_in(wire8(ana_pin_q, 8'h00)), .ana_pin_q(ana_pin_q),
      .ad_pin_in(wire8(ad_pin_q, ext_on ? ad_drive : bench_ad)),
      .ad_pin_q(ad_pin_q), .hi_pin_in(wire8(hi_pin_q, 8'h00)),
      .hi_pin_q(hi_pin_q), .led_pin_q(led_pin_q),
      .led_pin_in(wire8(led_pin_q, {1'b1, wait_n, 6'h3f})),
      .tmr8_pin_in(tmr8_pin_in), .serial_busy_pin(serial_busy_pin),
      .serial_auto_strobe_q(serial_auto_strobe_q),
      .timer16_out_q(timer16_out_q), .prom_pin_in(prom_pin_in),
      .feedback_resistor_cut(fbc), .tmr16_pwm(tmr16_pwm),
      .serial_stb_int(serial_stb_int), .ext_req(ext_req),
      .ext_done_q(ext_done_q), .ext_rdata_q(ext_rdata_q),
      .timer_count_q(timer_count_q), .serial_busy_q(serial_busy_q),
      .ext_irq_pulse_q(ext_irq_pulse_q),
      .memory_size_select_q(memory_size_select_q),
      .expansion_ram_size_select_q(expansion_ram_size_select_q),
      .prom_mode_q(prom_mode_q));
   pfm_ext_mem ext_mem (.hclk(hclk), .ad_pin_q(ad_pin_q),
      .hi_pin_q(hi_pin_q), .led_pin_q(led_pin_q), .wait_cyc(wait_cyc),
      .ad_drive(ad_drive), .wait_n(wait_n), .hi_lat(hi_lat));
   // ==========================================================
   // Bus and check tasks
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Waits five cycles and gathers every interrupt pulse seen
   task automatic pulse_wait(output logic [3:0] s);
      s = 4'h0;
      repeat (5) begin
         @(posedge hclk);
         s = s | ext_irq_pulse_q;
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         $display("Error %0t: got %h want %h", $time, g, e);
         n_fail++;
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      chk(x, e);
      chk(hresp, 32'h0);
   endtask
   task automatic ext(input logic we, input logic [15:0] a,
         input logic [7:0] d);
      ext_req <= '{1'b1, we, a, d};
      @(posedge hclk);
      while (ext_done_q !== 1'b1) @(posedge hclk);
      ext_req.valid <= 1'b0;
      wt(12);
   endtask
   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      n_fail++;
      end_of_test();
   end
   // ==========================================================
   // Scenarios
   initial begin
      logic [31:0] r, p;
      logic [3:0] s;
      wt(8);
      hresetn <= 1'b1;
      wt(1);
      rdc(PFM_OFF_MEM_SIZE, 32'hcf);
      rdc(PFM_OFF_XRAM_SIZE, 32'ha);
      rdc(PFM_OFF_DIR, 32'h0);
      wr(PFM_OFF_MEM_SIZE, 32'hc6);
      rdc(PFM_OFF_MEM_SIZE, 32'hc6);
      for (int i = 0; i < 2; i++) begin
         fbc <= i[0];
         ahb(1'b0, PFM_OFF_PIN_LO, 32'h0, r);
         chk(r[4], i[0]);
      end
      chk({ad_pin_q.oe, hi_pin_q.oe, led_pin_q.oe}, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         r = $random(seed) & 32'hffff_ff0e;
         p = $random(seed);
         wr(PFM_OFF_CTRL, {27'h0, i[0], 4'h0});
         wr(PFM_OFF_DIR, r);
         wr(PFM_OFF_PULL, p);
         wt(3);
         chk(hi_pin_q.oe, r[23:16]);
         chk(hi_pin_q.pu, p[23:16] & ~r[23:16]);
         chk(small_pin_q.oe, {4'h0, r[3:1], 1'b0});
         chk(small_pin_q.pu, {4'h0, p[3:1] & ~r[3:1], 1'b0});
         chk(led_pin_q.pu, {p[31:28] & ~r[31:28], 4'h0});
         chk(ad_pin_q.oe, {8{i[0]}});
         chk(ad_pin_q.pu, {8{p[4] & ~i[0]}});
      end
      wr(PFM_OFF_DIR, 32'h0);
      wr(PFM_OFF_PULL, 32'h0000_ff00);
      for (int i = 0; i < 2; i++) begin
         wr(PFM_OFF_CTRL, {30'h0, i[0], 1'b0});
         wt(3);
         chk(ana_pin_q.pu, {8{~i[0]}});
      end
      $display("test directions done");
      wr(PFM_OFF_FLAGS, 32'h1f);
      rdc(PFM_OFF_FLAGS, 32'h0);
      bench_ad <= 8'hff ^ (8'h1 << ({$random(seed)} % 8));
      wt(5);
      rdc(PFM_OFF_FLAGS, 32'h10);
      for (int c = 0; c < 4; c++) begin
         for (int m = 1; m < 4; m++) begin
            wr(PFM_OFF_FLAGS, 32'h1f);
            wr(PFM_OFF_EDGE, c < 3 ? 32'(m) << (2 * c) : 32'h40);
            small_pin_in[c] <= 1'b1;
            pulse_wait(s);
            chk(s, eflag(c, m, 0));
            rdc(PFM_OFF_FLAGS, eflag(c, m, 0));
            wr(PFM_OFF_FLAGS, 32'h1f);
            small_pin_in[c] <= 1'b0;
            pulse_wait(s);
            chk(s, eflag(c, m, 1));
            rdc(PFM_OFF_FLAGS, eflag(c, m, 1));
         end
      end
      $display("test edges done");
      wr(PFM_OFF_CTRL, 32'h1);
      ext_on <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         r = $random(seed);
         wait_cyc <= 4'(i * 3);
         ext(1'b1, r[15:0], r[23:16]);
         ext(1'b0, r[15:0], 8'h00);
         chk(ext_rdata_q, r[23:16]);
         chk(hi_lat, r[15:8]);
      end
      ext_on <= 1'b0;
      $display("test external bus done");
      wr(PFM_OFF_CTRL, 32'hc);
      for (int i = 0; i < 9; i++) begin
         r = $random(seed);
         {serial_busy_pin, serial_stb_int, tmr16_pwm} <= r[5:3];
         {small_pin_in[0], tmr8_pin_in} <= r[2:0];
         prom_pin_in <= PCODE[i];
         wt(5);
         chk({serial_busy_q, serial_auto_strobe_q, timer16_out_q,
            timer_count_q}, {r[5:3], r[1:0], r[2]});
         chk(prom_mode_q, 32'(i));
      end
      $display("test functions done");
      end_of_test();
   end
endmodule

/* File: verilog/pfm_edge_det.sv */
// Per-channel rising/falling edge detector on synchronised levels
`timescale 1ns/1ps
module pfm_edge_det #(
   parameter int N = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Levels and edge selection
   input wire logic [N-1:0] lvl,
   input wire logic [N-1:0] rise_en,
   input wire logic [N-1:0] fall_en,
   // One-cycle hits
   output logic [N-1:0] hit
);
   logic [N-1:0] prev_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= '0;
      end else if (clk_en) begin
         prev_q <= lvl;
      end
   end

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_ch
         assign hit[i] = (rise_en[i] & lvl[i] & ~prev_q[i]) |
                         (fall_en[i] & ~lvl[i] & prev_q[i]);
      end
   endgenerate
endmodule

/* File: verilog/pfm_pkg.sv */
// Package for the port and pin-function map: offsets, resets, types
package pfm_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] PFM_OFF_CTRL = 8'h00;
   localparam logic [7:0] PFM_OFF_DIR = 8'h04;
   localparam logic [7:0] PFM_OFF_PULL = 8'h08;
   localparam logic [7:0] PFM_OFF_OUT_LO = 8'h0c;
   localparam logic [7:0] PFM_OFF_OUT_HI = 8'h10;
   localparam logic [7:0] PFM_OFF_PIN_LO = 8'h14;
   localparam logic [7:0] PFM_OFF_PIN_HI = 8'h18;
   localparam logic [7:0] PFM_OFF_EDGE = 8'h1c;
   localparam logic [7:0] PFM_OFF_FLAGS = 8'h20;
   localparam logic [7:0] PFM_OFF_MEM_SIZE = 8'h24;
   localparam logic [7:0] PFM_OFF_XRAM_SIZE = 8'h28;
   localparam logic [7:0] PFM_OFF_PROM = 8'h2c;

   // ==========================================================
   // Field positions
   localparam int PFM_CTRL_EXT = 0;
   localparam int PFM_CTRL_ANA = 1;
   localparam int PFM_CTRL_T16 = 2;
   localparam int PFM_CTRL_STB = 3;
   localparam int PFM_CTRL_AD_DIR = 4;
   localparam int PFM_EDGE_CH3_EN = 6;
   localparam int PFM_FLAG_KEY = 4;

   // ==========================================================
   // Values after reset
   localparam logic [4:0] PFM_CTRL_RST = 5'h00;
   localparam logic [31:0] PFM_ZERO_RST = 32'h0000_0000;
   localparam logic [6:0] PFM_EDGE_RST = 7'h00;
   localparam logic [4:0] PFM_FLAGS_RST = 5'h00;
   localparam logic [7:0] PFM_MEM_SIZE_RST = 8'hcf;
   localparam logic [3:0] PFM_XRAM_SIZE_RST = 4'ha;

   // ==========================================================
   // Counts of cycles
   localparam logic [1:0] PFM_STRB_MIN_CYC = 2'h3;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
      logic [7:0] pu;
   } pfm_pin8_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } pfm_ext_req_t;

   typedef enum logic [1:0] {
      PFM_ST_IDLE = 2'b00,
      PFM_ST_ADDR = 2'b01,
      PFM_ST_STRB = 2'b10,
      PFM_ST_DONE = 2'b11
   } pfm_ext_st_t;

   typedef enum logic [3:0] {
      PFM_PM_OFF = 4'h0,
      PFM_PM_READ = 4'h1,
      PFM_PM_ODIS = 4'h2,
      PFM_PM_STBY = 4'h3,
      PFM_PM_PLATCH = 4'h4,
      PFM_PM_PWRITE = 4'h5,
      PFM_PM_BWRITE = 4'h6,
      PFM_PM_VERIFY = 4'h7,
      PFM_PM_INHIBIT = 4'h8
   } pfm_prom_mode_t;

endpackage

/* File: verilog/pfm_port_map.sv */
// Port direction, pull-up, pin-function and external bus top block
`timescale 1ns/1ps
module pfm_port_map (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Port pins
   input wire logic [4:0] small_pin_in,
   output pfm_pkg::pfm_pin8_t small_pin_q,
   input wire logic [7:0] ana_pin_in,
   output pfm_pkg::pfm_pin8_t ana_pin_q,
   input wire logic [7:0] ad_pin_in,
   output pfm_pkg::pfm_pin8_t ad_pin_q,
   input wire logic [7:0] hi_pin_in,
   output pfm_pkg::pfm_pin8_t hi_pin_q,
   input wire logic [7:0] led_pin_in,
   output pfm_pkg::pfm_pin8_t led_pin_q,
   // Dedicated function pins
   input wire logic [1:0] tmr8_pin_in,
   input wire logic serial_busy_pin,
   output logic serial_auto_strobe_q,
   output logic timer16_out_q,
   // Programming pins
   input wire logic [5:0] prom_pin_in,
   // Chip-side connections
   input wire logic feedback_resistor_cut,
   input wire logic tmr16_pwm,
   input wire logic serial_stb_int,
   input wire pfm_pkg::pfm_ext_req_t ext_req,
   output logic ext_done_q,
   output logic [7:0] ext_rdata_q,
   output logic [2:0] timer_count_q,
   output logic serial_busy_q,
   output logic [3:0] ext_irq_pulse_q,
   output logic [7:0] memory_size_select_q,
   output logic [3:0] expansion_ram_size_select_q,
   output pfm_pkg::pfm_prom_mode_t prom_mode_q
);
   import pfm_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [4:0] small_s;
   logic [7:0] ana_s, ad_s, hi_s, led_s;
   logic [1:0] tmr8_s;
   logic busy_s;
   logic [5:0] prom_s;

   pfm_sync2 #(.W(46)) u_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .clk_en(clk_en),
      .d({small_pin_in, ana_pin_in, ad_pin_in, hi_pin_in, led_pin_in,
          tmr8_pin_in, serial_busy_pin, prom_pin_in}),
      .q({small_s, ana_s, ad_s, hi_s, led_s, tmr8_s, busy_s, prom_s})
   );

   // ==========================================================
   // Registers
   logic [4:0] ctrl_q;
   logic [31:0] dir_q, pull_q, out_lo_q, out_hi_q;
   logic [6:0] edge_q;
   logic [4:0] flags_q;
   pfm_ext_st_t st_q;

   // ==========================================================
   // AHB-Lite slave: writes commit in the data phase, reads take
   // one wait state so a read right after a write sees new data
   logic pend_q, pend_wr_q;
   logic [7:0] pend_addr_q;
   logic take, wr_en;

   assign take = hsel & htrans[1] & hready;
   assign wr_en = pend_q & pend_wr_q;

   function automatic logic hit_off(input logic [7:0] a,
                                    input logic [7:0] off);
      hit_off = (a == off);
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_q <= 1'b0;
         pend_wr_q <= 1'b0;
         pend_addr_q <= 8'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else if (clk_en) begin
         if (take) begin
            pend_q <= 1'b1;
            pend_wr_q <= hwrite;
            pend_addr_q <= haddr[7:0];
            hreadyout <= hwrite;
         end else if (pend_q && !hreadyout) begin
            pend_q <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= read_mux(pend_addr_q);
         end else begin
            pend_q <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] read_mux(input logic [7:0] a);
      read_mux = 32'h0000_0000;
      if (hit_off(a, PFM_OFF_CTRL)) read_mux = {27'h0, ctrl_q};
      if (hit_off(a, PFM_OFF_DIR)) read_mux = dir_q;
      if (hit_off(a, PFM_OFF_PULL)) read_mux = pull_q;
      if (hit_off(a, PFM_OFF_OUT_LO)) read_mux = out_lo_q;
      if (hit_off(a, PFM_OFF_OUT_HI)) read_mux = out_hi_q;
      if (hit_off(a, PFM_OFF_PIN_LO)) begin
         // Pin 4 reads zero until the oscillator feedback is cut
         read_mux = {8'h00, ad_s, ana_s, 3'h0,
                     small_s[4] & feedback_resistor_cut, small_s[3:0]};
      end
      if (hit_off(a, PFM_OFF_PIN_HI)) read_mux = {16'h0, led_s, hi_s};
      if (hit_off(a, PFM_OFF_EDGE)) read_mux = {25'h0, edge_q};
      if (hit_off(a, PFM_OFF_FLAGS)) read_mux = {27'h0, flags_q};
      if (hit_off(a, PFM_OFF_MEM_SIZE)) begin
         read_mux = {24'h0, memory_size_select_q};
      end
      if (hit_off(a, PFM_OFF_XRAM_SIZE)) begin
         read_mux = {28'h0, expansion_ram_size_select_q};
      end
      if (hit_off(a, PFM_OFF_PROM)) read_mux = {28'h0, prom_mode_q};
   endfunction

   // Control, direction, pull-up and output latches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= PFM_CTRL_RST;
         dir_q <= PFM_ZERO_RST;
         pull_q <= PFM_ZERO_RST;
         out_lo_q <= PFM_ZERO_RST;
         out_hi_q <= PFM_ZERO_RST;
         edge_q <= PFM_EDGE_RST;
      end else if (clk_en && wr_en) begin
         if (hit_off(pend_addr_q, PFM_OFF_CTRL)) ctrl_q <= hwdata[4:0];
         if (hit_off(pend_addr_q, PFM_OFF_DIR)) dir_q <= hwdata;
         if (hit_off(pend_addr_q, PFM_OFF_PULL)) pull_q <= hwdata;
         if (hit_off(pend_addr_q, PFM_OFF_OUT_LO)) out_lo_q <= hwdata;
         if (hit_off(pend_addr_q, PFM_OFF_OUT_HI)) out_hi_q <= hwdata;
         if (hit_off(pend_addr_q, PFM_OFF_EDGE)) edge_q <= hwdata[6:0];
      end
   end

   // Memory size selections
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         memory_size_select_q <= PFM_MEM_SIZE_RST;
         expansion_ram_size_select_q <= PFM_XRAM_SIZE_RST;
      end else if (clk_en && wr_en) begin
         if (hit_off(pend_addr_q, PFM_OFF_MEM_SIZE)) begin
            memory_size_select_q <= hwdata[7:0];
         end
         if (hit_off(pend_addr_q, PFM_OFF_XRAM_SIZE)) begin
            expansion_ram_size_select_q <= hwdata[3:0];
         end
      end
   end

   // ==========================================================
   // Edge detection and flags
   logic [3:0] irq_hit;
   logic [7:0] ad_fall;
   logic [4:0] flag_set, flag_clr;

   pfm_edge_det #(.N(4)) u_irq_edge (
      .clk(hclk),
      .rst_n(hresetn),
      .clk_en(clk_en),
      .lvl(small_s[3:0]),
      .rise_en({1'b0, edge_q[4], edge_q[2], edge_q[0]}),
      .fall_en({edge_q[PFM_EDGE_CH3_EN], edge_q[5], edge_q[3],
                edge_q[1]}),
      .hit(irq_hit)
   );

   pfm_edge_det #(.N(8)) u_key_edge (
      .clk(hclk),
      .rst_n(hresetn),
      .clk_en(clk_en),
      .lvl(ad_s),
      .rise_en(8'h00),
      .fall_en(8'hff),
      .hit(ad_fall)
   );

   assign flag_set = {|ad_fall, irq_hit};
   assign flag_clr = (wr_en && hit_off(pend_addr_q, PFM_OFF_FLAGS)) ?
                     hwdata[4:0] : 5'h00;

   // Sticky flags, write one to clear; a new event wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= PFM_FLAGS_RST;
         ext_irq_pulse_q <= 4'h0;
      end else if (clk_en) begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
         ext_irq_pulse_q <= irq_hit;
      end
   end

   // ==========================================================
   // External memory access sequencer
   logic ext_mode, wait_n_s;
   logic [1:0] strb_cnt_q;
   logic [15:0] ext_addr_q;
   logic [7:0] ext_wdata_q;
   logic ext_we_q;

   assign ext_mode = ctrl_q[PFM_CTRL_EXT];
   assign wait_n_s = led_s[6];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= PFM_ST_IDLE;
         strb_cnt_q <= 2'h0;
         ext_addr_q <= 16'h0000;
         ext_wdata_q <= 8'h00;
         ext_we_q <= 1'b0;
         ext_done_q <= 1'b0;
         ext_rdata_q <= 8'h00;
      end else if (clk_en) begin
         ext_done_q <= 1'b0;
         unique case (st_q)
            PFM_ST_IDLE: begin
               // Skip the done cycle so a held request is not taken twice
               if (ext_mode && ext_req.valid && !ext_done_q) begin
                  ext_addr_q <= ext_req.addr;
                  ext_wdata_q <= ext_req.wdata;
                  ext_we_q <= ext_req.we;
                  st_q <= PFM_ST_ADDR;
               end
            end
            PFM_ST_ADDR: begin
               strb_cnt_q <= 2'h0;
               st_q <= PFM_ST_STRB;
            end
            PFM_ST_STRB: begin
               if (strb_cnt_q != PFM_STRB_MIN_CYC) begin
                  strb_cnt_q <= strb_cnt_q + 2'h1;
               end else if (wait_n_s) begin
                  st_q <= PFM_ST_DONE;
               end
            end
            PFM_ST_DONE: begin
               ext_rdata_q <= ad_s;
               ext_done_q <= 1'b1;
               st_q <= PFM_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Pin drivers
   logic [7:0] ana_pu, led_dir;
   logic rd_act, wr_act;

   assign ana_pu = pull_q[15:8] & ~dir_q[15:8] &
                   ~{8{ctrl_q[PFM_CTRL_ANA]}};
   assign led_dir = dir_q[31:24];
   assign rd_act = (st_q == PFM_ST_STRB) && !ext_we_q;
   assign wr_act = (st_q == PFM_ST_STRB) && ext_we_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         small_pin_q <= '0;
         ana_pin_q <= '0;
         ad_pin_q <= '0;
         hi_pin_q <= '0;
         led_pin_q <= '0;
      end else if (clk_en) begin
         small_pin_q.o <= {4'h0, out_lo_q[3:1], 1'b0};
         small_pin_q.oe <= {4'h0, dir_q[3:1], 1'b0};
         small_pin_q.pu <= {4'h0, pull_q[3:1] & ~dir_q[3:1], 1'b0};
         ana_pin_q.o <= out_lo_q[15:8];
         ana_pin_q.oe <= dir_q[15:8];
         ana_pin_q.pu <= ana_pu;
         if (ext_mode) begin
            ad_pin_q.o <= (st_q == PFM_ST_ADDR) ? ext_addr_q[7:0] :
                          ext_wdata_q;
            ad_pin_q.oe <= {8{(st_q == PFM_ST_ADDR) || wr_act}};
            ad_pin_q.pu <= 8'h00;
            hi_pin_q.o <= ext_addr_q[15:8];
            hi_pin_q.oe <= 8'hff;
            hi_pin_q.pu <= 8'h00;
            led_pin_q.o[7:4] <= {st_q == PFM_ST_ADDR, 1'b0,
                                 !wr_act, !rd_act};
            led_pin_q.oe[7:4] <= 4'hb;
            led_pin_q.pu[7:4] <= 4'h0;
         end else begin
            ad_pin_q.o <= out_lo_q[23:16];
            ad_pin_q.oe <= {8{ctrl_q[PFM_CTRL_AD_DIR]}};
            ad_pin_q.pu <= {8{pull_q[4] & ~ctrl_q[PFM_CTRL_AD_DIR]}};
            hi_pin_q.o <= out_hi_q[7:0];
            hi_pin_q.oe <= dir_q[23:16];
            hi_pin_q.pu <= pull_q[23:16] & ~dir_q[23:16];
            led_pin_q.o[7:4] <= out_hi_q[15:12];
            led_pin_q.oe[7:4] <= led_dir[7:4];
            led_pin_q.pu[7:4] <= pull_q[31:28] & ~led_dir[7:4];
         end
         // Open-drain: only ever pulls low, never a pull-up
         led_pin_q.o[3:0] <= 4'h0;
         led_pin_q.oe[3:0] <= led_dir[3:0] & ~out_hi_q[11:8];
         led_pin_q.pu[3:0] <= 4'h0;
      end
   end

   // ==========================================================
   // Timer, serial and programming-mode functions
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_count_q <= 3'h0;
         timer16_out_q <= 1'b0;
         serial_auto_strobe_q <= 1'b0;
         serial_busy_q <= 1'b0;
      end else if (clk_en) begin
         timer_count_q <= {tmr8_s, small_s[0]};
         timer16_out_q <= ctrl_q[PFM_CTRL_T16] & tmr16_pwm;
         serial_auto_strobe_q <= ctrl_q[PFM_CTRL_STB] &
                                 serial_stb_int;
         serial_busy_q <= busy_s;
      end
   end

   // prom_s: {reset low, vpp on, vpp high, ce_n, oe_n, pgm_n}
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prom_mode_q <= PFM_PM_OFF;
      end else if (clk_en) begin
         if (!(prom_s[5] && prom_s[4])) begin
            prom_mode_q <= PFM_PM_OFF;
         end else if (prom_s[3]) begin
            unique case (prom_s[2:0])
               3'b101: prom_mode_q <= PFM_PM_PLATCH;
               3'b110: prom_mode_q <= PFM_PM_PWRITE;
               3'b010: prom_mode_q <= PFM_PM_BWRITE;
               3'b001: prom_mode_q <= PFM_PM_VERIFY;
               default: prom_mode_q <= PFM_PM_INHIBIT;
            endcase
         end else if (prom_s[2]) begin
            prom_mode_q <= PFM_PM_STBY;
         end else if (prom_s[1]) begin
            prom_mode_q <= PFM_PM_ODIS;
         end else begin
            prom_mode_q <= PFM_PM_READ;
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   small_input_only_a: assert property (
      small_pin_q.oe[0] == 1'b0 && small_pin_q.oe[4] == 1'b0)
      else $error("input-only pin driven");
   ad_dir_whole_a: assert property (
      !ext_mode |-> (ad_pin_q.oe == 8'h00 || ad_pin_q.oe == 8'hff))
      else $error("address/data port direction split");
   key_flag_set_a: assert property (
      (clk_en && ad_fall != 8'h00) |=> flags_q[PFM_FLAG_KEY])
      else $error("key-return flag missed a falling edge");
   led_open_drain_a: assert property (
      led_pin_q.o[3:0] == 4'h0 && led_pin_q.pu[3:0] == 4'h0)
      else $error("open-drain pin drove high or pulled up");
   irq3_rise_a: assert property (
      (clk_en && small_s[3] && !$past(small_s[3])) |=> !ext_irq_pulse_q[3])
      else $error("interrupt 3 took a rising edge");
   analog_pull_a: assert property (
      (clk_en && ctrl_q[PFM_CTRL_ANA]) |=> ana_pin_q.pu == 8'h00)
      else $error("analog port pull-up left on");
   size_write_a: assert property (
      $changed(memory_size_select_q) |-> $past(wr_en))
      else $error("memory size changed without a write");
   wait_holds_a: assert property (
      (clk_en && st_q == PFM_ST_STRB && strb_cnt_q == PFM_STRB_MIN_CYC &&
       !wait_n_s) |=> st_q == PFM_ST_STRB)
      else $error("access ended while wait was asserted");
   strobe_order_a: assert property (
      (clk_en && st_q == PFM_ST_ADDR) |=> led_pin_q.o[7] ##0
      (st_q == PFM_ST_STRB))
      else $error("address strobe not issued before access");
   rd_wr_excl_a: assert property (
      $past(ext_mode) |-> (led_pin_q.o[4] || led_pin_q.o[5]))
      else $error("read and write strobes both active");

   ext_read_c: cover property (st_q == PFM_ST_DONE && !ext_we_q);
   ext_write_c: cover property (st_q == PFM_ST_DONE && ext_we_q);
   key_flag_c: cover property (flag_set[PFM_FLAG_KEY] && flag_clr[4]);
endmodule

/* File: verilog/pfm_sync2.sv */
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pfm_sync2 #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else if (clk_en) begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
